//--- dv/sec_spi_channel_test.sv
`timescale 1ns/1ps
`default_nettype none

module sec_spi_channel_test;
   import sec_pkg::*;
   logic clk_i;
   logic rst_i;
   sec_wb_req_s wb_req;
   logic [31:0] wb_dat;
   logic [31:0] q;
   logic wb_ack, sclk, m_sclk, mosi, miso, sel_n, irq;
   logic [7:0] tx_byte;
   logic [15:0] tx_index;
   int error_cnt, samples_checked, cyc;
   logic [15:0] rx_index;
   logic [7:0] rx_byte, out_q;
   logic rx_vld, tx_req, m_mosi, sclk_oe, mosi_oe, miso_oe, s_miso, slv, cent_pend, cent_clr;
   logic [31:0] cent_mask;
   int tx_reqs;

   assign tx_byte = 8'h30 + tx_index[7:0];

   sec_spi_channel #(.DIV_BASE(1)) sec_spi_channel_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_req_i(wb_req), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .spi_sclk_i(sclk),
      .spi_sclk_o(m_sclk), .spi_sclk_oe_o(sclk_oe), .spi_mosi_i(mosi), .spi_mosi_o(m_mosi),
      .spi_mosi_oe_o(mosi_oe), .spi_miso_i(miso), .spi_miso_o(s_miso), .spi_miso_oe_o(miso_oe),
      .slave_select_n_i(sel_n), .tx_byte_i(tx_byte), .tx_byte_req_o(tx_req),
      .tx_index_o(tx_index), .rx_byte_o(rx_byte), .rx_byte_vld_o(rx_vld),
      .rx_index_o(rx_index), .irq_o(irq));

   sec_spi_peer sec_spi_peer_inst (.sclk_i(m_sclk), .miso_o(miso));

   // data-out byte as the far side sees it, per role
   always @(posedge m_sclk or posedge sclk) begin
      out_q <= {out_q[6:0], slv ? s_miso : m_mosi};
   end

   // every stored byte: received value and the byte sent alongside it
   always @(posedge clk_i) begin
      if (tx_req) begin
         tx_reqs <= tx_reqs + 1;
      end
      if (rx_vld) begin
         chk({24'h000000, rx_byte}, slv ? {16'h0000, rx_index - 16'h0001} : 32'h000000C3);
         chk({24'h000000, out_q}, {16'h0000, rx_index + 16'h002F});
      end
   end

   // central controller model: channel line is bit 5 of its mask
   always @(posedge clk_i) begin
      if (rst_i || cent_clr) begin
         cent_pend <= 1'b0;
      end else if (irq && cent_mask[5]) begin
         cent_pend <= 1'b1;
      end
   end

   // ****************
   // helpers
   // ****************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
      do begin
         @(posedge clk_i);
      end while (wb_ack !== 1'b1);
      q = wb_dat;
      wb_req <= '0;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask

   task automatic wait_ev(input logic [7:0] m);
      int n;
      n = 0;
      do begin
         wb(1'b0, 8'h00, 32'h0);
         n++;
      end while ((q[7:0] & m) !== m && n < 200);
   endtask

   // whole bytes only; a partial byte would be dropped
   task automatic frame(input int cnt);
      sel_n <= 1'b0;
      for (int k = 0; k < cnt; k++) begin
         for (int i = 7; i >= 0; i--) begin
            mosi <= k[i];
            repeat (4) @(posedge clk_i);
            sclk <= 1'b1;
            repeat (4) @(posedge clk_i);
            sclk <= 1'b0;
         end
      end
      sel_n <= 1'b1;
      mosi <= ~mosi;
      repeat (8) @(posedge clk_i);
   endtask

   // ****************
   // scenarios
   // ****************
   task automatic t_regs();
      rd(8'h00, 32'hFF, 32'h0);
      rd(8'h04, 32'hFF, 32'h0);
      wb(1'b1, 8'h04, 32'h37);
      rd(8'h04, 32'hFFFFFFFF, 32'h37);
      rd(8'h34, 32'hFFFFFFFF, 32'h0);
      wb(1'b1, 8'h1C, 32'h10);
      wb(1'b1, 8'h20, 32'h18);
      wb(1'b1, 8'h2C, 32'h1);
      rd(8'h24, 32'hFFFF, 32'h10);
      rd(8'h28, 32'hFFFF, 32'h18);
      $display("test regs done");
   endtask

   task automatic t_master();
      wb(1'b1, 8'h18, 32'h10);
      wb(1'b1, 8'h14, 32'h5);
      wb(1'b1, 8'h10, 32'h7);
      wb(1'b1, 8'h08, 32'h370);
      cent_mask <= 32'h00000020;
      wb(1'b1, 8'h0C, 32'h80);
      wait_ev(8'h03);
      rd(8'h00, 32'hFF, 32'h03);
      chk(tx_reqs, 32'h5);
      chk({29'h0, sclk_oe, mosi_oe, miso_oe}, 32'h6);
      rd(8'h30, 32'hFFFF, 32'h5);
      chk(tx_index, 32'h5);
      chk(irq, 32'h1);
      chk(cent_pend, 32'h1);
      wb(1'b1, 8'h04, 32'h0);
      rd(8'h00, 32'hFF, 32'h03);
      chk(irq, 32'h0);
      wb(1'b1, 8'h04, 32'h37);
      wb(1'b1, 8'h00, 32'h01);
      rd(8'h00, 32'hFF, 32'h02);
      chk(irq, 32'h1);
      wb(1'b1, 8'h00, 32'h02);
      rd(8'h00, 32'hFF, 32'h0);
      chk(irq, 32'h0);
      cent_clr <= 1'b1;
      @(posedge clk_i);
      cent_clr <= 1'b0;
      @(posedge clk_i);
      chk(cent_pend, 32'h0);
      $display("test master done");
   endtask

   task automatic t_slave(input int len, input int cnt, input logic [7:0] e);
      slv <= 1'b1;
      wb(1'b1, 8'h00, 32'hFF);
      wb(1'b1, 8'h18, len);
      wb(1'b1, 8'h14, len);
      wb(1'b1, 8'h10, 32'h3);
      wb(1'b1, 8'h08, 32'h170);
      wb(1'b1, 8'h0C, 32'h80);
      frame(cnt);
      rd(8'h00, 32'hFF, e);
      chk({29'h0, sclk_oe, mosi_oe, miso_oe}, 32'h0);
      $display("test slave done");
   endtask

   task automatic t_mme();
      wb(1'b1, 8'h00, 32'hFF);
      wb(1'b1, 8'h08, 32'h370);
      wb(1'b1, 8'h10, 32'h7);
      sel_n <= 1'b0;
      wb(1'b1, 8'h0C, 32'h80);
      repeat (8) @(posedge clk_i);
      rd(8'h00, 32'h20, 32'h20);
      sel_n <= 1'b1;
      $display("test mme done");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // hang guard well above the expected run length
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end

   initial begin
      rst_i = 1'b1;
      wb_req = '0;
      sclk = 1'b0;
      mosi = 1'b0;
      sel_n = 1'b1;
      cyc = 0;
      error_cnt = 0;
      samples_checked = 0;
      slv = 1'b0;
      tx_reqs = 0;
      cent_mask = 32'h0;
      cent_clr = 1'b0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_master();
      t_slave(16, 3, 8'h01);
      t_slave(2, 3, 8'h07);
      t_slave(2, 2, 8'h03);
      t_mme();
      results();
   end
endmodule

`default_nettype wire

//--- dv/sec_spi_peer.sv
`timescale 1ns/1ps
`default_nettype none

// ****************
// far-side slave
// ****************
module sec_spi_peer (
   // serial link
   input wire logic sclk_i,
   output logic miso_o
);
   logic [7:0] sh_q = 8'hC3;

   // rotating keeps every byte equal to the seed
   always @(negedge sclk_i) begin
      sh_q <= {sh_q[6:0], sh_q[7]};
   end
   assign miso_o = sh_q[7];
endmodule

`default_nettype wire

//--- verilog/sec_baud_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "sec_defines.svh"

module sec_baud_div #(
   parameter int DIV_BASE = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   input wire logic [3:0] pm_i,
   // enable out
   output logic tick_o
);
   import sec_pkg::*;

   sec_div_s s, n;
   logic [15:0] limit;

   generate
      if (DIV_BASE < 1 || DIV_BASE > 4096) begin : g_bad
         $error("sec_baud_div: DIV_BASE out of range");
      end
   endgenerate

   // period is (pm + 1) * DIV_BASE cycles per half bit
   assign limit = 16'(({12'h000, pm_i} + `SEC_ONE_16) * 16'(DIV_BASE) - `SEC_ONE_16);

   always_comb begin
      n = s;
      n.tick = 1'b0;
      if (!run_i) begin
         n.cnt = `SEC_RST_16;
      end else if (s.cnt >= limit) begin
         n.cnt = `SEC_RST_16;
         n.tick = 1'b1;
      end else begin
         n.cnt = s.cnt + `SEC_ONE_16;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign tick_o = s.tick;
endmodule

`default_nettype wire

//--- verilog/sec_defines.svh
`ifndef SEC_DEFINES_SVH
`define SEC_DEFINES_SVH

// ********************************************************************
// register byte addresses
// ********************************************************************
`define SEC_ADR_EVENT 8'h00
`define SEC_ADR_MASK 8'h04
`define SEC_ADR_MODE 8'h08
`define SEC_ADR_CMD 8'h0C
`define SEC_ADR_DESC 8'h10
`define SEC_ADR_TX_LEN 8'h14
`define SEC_ADR_MAX_RX 8'h18
`define SEC_ADR_RX_BASE 8'h1C
`define SEC_ADR_TX_BASE 8'h20
`define SEC_ADR_RX_PTR 8'h24
`define SEC_ADR_TX_PTR 8'h28
`define SEC_ADR_PROC_CMD 8'h2C
`define SEC_ADR_STATUS 8'h30

// ********************************************************************
// field positions
// ********************************************************************
`define SEC_EV_RXB 0
`define SEC_EV_TXB 1
`define SEC_EV_BSY 2
`define SEC_EV_TXE 4
`define SEC_EV_MME 5
`define SEC_EV_USED 8'h37
`define SEC_MODE_MASTER 9
`define SEC_MODE_ENABLE 8
`define SEC_MODE_PM_HI 3
`define SEC_CMD_START 7
`define SEC_DESC_TX_READY 0
`define SEC_DESC_RX_EMPTY 1
`define SEC_DESC_TX_LAST 2
`define SEC_PCMD_INIT 0
`define SEC_STAT_RX_LAST 16
`define SEC_STAT_MME 17

// ********************************************************************
// values
// ********************************************************************
`define SEC_RST_8 8'h00
`define SEC_RST_16 16'h0000
`define SEC_FILL_BYTE 8'hFF
`define SEC_BIT_LAST 3'h7
`define SEC_ONE_16 16'h0001

`endif

//--- verilog/sec_pkg.sv
package sec_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOAD = 2'b01,
      ST_SHIFT = 2'b11
   } sec_state_e;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } sec_wb_req_s;

   typedef struct packed {
      logic [7:0] sh;
      logic [7:0] rx;
      logic [2:0] bits;
      logic busy;
      logic sclk;
      logic sclk_prev;
      logic done;
      logic sdo;
   } sec_eng_s;

   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } sec_div_s;

   typedef struct packed {
      sec_state_e st;
      logic [7:0] ev;
      logic [7:0] mask;
      logic [15:0] mode;
      logic tx_ready;
      logic rx_empty;
      logic tx_last;
      logic [15:0] tx_len;
      logic [15:0] max_rx;
      logic [15:0] rx_base;
      logic [15:0] tx_base;
      logic [15:0] rx_ptr;
      logic [15:0] tx_ptr;
      logic [15:0] tx_cnt;
      logic [15:0] rx_cnt;
      logic rx_last;
      logic mm_err;
      logic sel_seen;
      logic ld;
      logic [7:0] ld_data;
      logic tx_req;
      logic [7:0] rx_data;
      logic rx_vld;
      logic irq;
      logic ack;
      logic [31:0] rdat;
      logic sclk_oe;
      logic mosi_oe;
      logic miso_oe;
   } sec_main_s;

endpackage

//--- verilog/sec_shift_eng.sv
`timescale 1ns/1ps
`default_nettype none
`include "sec_defines.svh"

module sec_shift_eng (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic master_i,
   input wire logic tick_i,
   input wire logic load_i,
   input wire logic [7:0] load_data_i,
   // serial side
   input wire logic sclk_i,
   input wire logic sdi_master_i,
   input wire logic sdi_slave_i,
   input wire logic select_n_i,
   output logic sclk_o,
   output logic sdo_o,
   // byte side
   output logic [7:0] rx_data_o,
   output logic done_o
);
   import sec_pkg::*;

   sec_eng_s s, n;

   // mode 0 framing: sample on rising, shift on falling
   always_comb begin
      n = s;
      n.done = 1'b0;
      n.sclk_prev = sclk_i;
      if (load_i) begin
         n.sh = load_data_i;
         n.sdo = load_data_i[7];
         n.bits = 3'h0;
         n.busy = 1'b1;
      end else if (master_i) begin
         if (s.busy && tick_i) begin
            if (!s.sclk) begin
               n.sclk = 1'b1;
               n.rx = {s.rx[6:0], sdi_master_i};
            end else begin
               n.sclk = 1'b0;
               if (s.bits == `SEC_BIT_LAST) begin
                  n.busy = 1'b0;
                  n.done = 1'b1;
               end else begin
                  n.bits = s.bits + 3'h1;
                  n.sh = {s.sh[6:0], 1'b0};
                  n.sdo = s.sh[6];
               end
            end
         end
      end else if (select_n_i) begin
         n.bits = 3'h0;
         n.sclk = 1'b0;
      end else if (s.busy) begin
         if (sclk_i && !s.sclk_prev) begin
            n.rx = {s.rx[6:0], sdi_slave_i};
            if (s.bits == `SEC_BIT_LAST) begin
               n.busy = 1'b0;
               n.done = 1'b1;
            end else begin
               n.bits = s.bits + 3'h1;
            end
         end else if (!sclk_i && s.sclk_prev && s.bits != 3'h0) begin
            // first fall of a byte must not shift away its leading bit
            n.sh = {s.sh[6:0], 1'b0};
            n.sdo = s.sh[6];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign sclk_o = s.sclk;
   assign sdo_o = s.sdo;
   assign rx_data_o = s.rx;
   assign done_o = s.done;
endmodule

`default_nettype wire

//--- verilog/sec_spi_channel.sv
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sec_defines.svh"

//
// Contract
// R1: byte arriving with no receive descriptor sets no-buffer event, data dropped.
// R2: transmit-buffer event set when last byte enters the transmit path; slave role sets it only after that byte has shifted out.
// R3: software waits two more character times before data has left the pin.
// R4: receive-buffer event set only after last byte stored and descriptor closed.
// R5: 8-bit mask mirrors event layout, one enables, resets to zero.
// R6: init command copies ring bases into current descriptor pointers.
// R7: mode 0370 hex is master, enabled, 8-bit, fastest clock.
// R8: mode 0170 hex is enabled slave, divider ignored, master supplies clock.
// R9: start bit begins master transfer or arms slave for master clocking.
// R10: master closes last transmit descriptor and receive after same byte count.
// R11: slave select negation closes receive, leaves transmit descriptor open.
// R12: slave closes transmit descriptor once its length has been shifted out.
// R13: slave exactly-full receive then select negation closes without any error.
// R14: byte beyond maximum receive length closes full buffer, raises no-buffer.
// R15: software writes 37 hex to mask to enable every source.
// R16: software enables channel bit in the central interrupt mask.
// R17: handler reads, clears events, re-arms descriptors and start bit.
// R18: handler clears channel pending bit in central in-service register.
// R19: select pin routed internally so multi-master clashes can be seen.
// R20: event flag clears only on written one; several may clear together.
// R21: interrupt request stays until every unmasked flag is cleared.
// R22: select driven active while master sets the multi-master event.
// R23: interrupt request is OR of flags ANDed with mask, every cycle.
module sec_spi_channel #(
   parameter int DIV_BASE = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire sec_pkg::sec_wb_req_s wb_req_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // serial link
   input wire logic spi_sclk_i,
   output logic spi_sclk_o,
   output logic spi_sclk_oe_o,
   input wire logic spi_mosi_i,
   output logic spi_mosi_o,
   output logic spi_mosi_oe_o,
   input wire logic spi_miso_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_o,
   input wire logic slave_select_n_i,
   // buffer memory side
   input wire logic [7:0] tx_byte_i,
   output logic tx_byte_req_o,
   output logic [15:0] tx_index_o,
   output logic [7:0] rx_byte_o,
   output logic rx_byte_vld_o,
   output logic [15:0] rx_index_o,
   // interrupt
   output logic irq_o
);
   import sec_pkg::*;

   sec_main_s s, n;
   logic [7:0] ev_set, ev_clr;
   logic req, wr, start_wr, init_wr, ev_wr, is_master, enabled;
   logic tick, eng_done, eng_sclk, eng_sdo;
   logic [7:0] eng_rx;

   function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
      lane16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction

   // ********************************************************************
   // bus decode
   // ********************************************************************
   // writes land on the edge where the master sees ack
   assign req = wb_req_i.cyc && wb_req_i.stb;
   assign wr = req && wb_req_i.we && s.ack;
   assign start_wr = wr && wb_req_i.adr == `SEC_ADR_CMD && wb_req_i.sel[0]
                     && wb_req_i.dat[`SEC_CMD_START];
   assign init_wr = wr && wb_req_i.adr == `SEC_ADR_PROC_CMD && wb_req_i.sel[0]
                    && wb_req_i.dat[`SEC_PCMD_INIT];
   assign ev_wr = wr && wb_req_i.adr == `SEC_ADR_EVENT && wb_req_i.sel[0];
   assign is_master = s.mode[`SEC_MODE_MASTER];
   assign enabled = s.mode[`SEC_MODE_ENABLE];

   // ********************************************************************
   // submodules
   // ********************************************************************
   // slave role ignores the divider: master supplies the clock [R8]
   sec_baud_div #(.DIV_BASE(DIV_BASE)) u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(enabled && is_master && s.st != ST_IDLE),
      .pm_i(s.mode[`SEC_MODE_PM_HI:0]),
      .tick_o(tick)
   );

   sec_shift_eng u_eng (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .master_i(is_master),
      .tick_i(tick),
      .load_i(s.ld),
      .load_data_i(s.ld_data),
      .sclk_i(spi_sclk_i),
      .sdi_master_i(spi_miso_i),
      .sdi_slave_i(spi_mosi_i),
      .select_n_i(slave_select_n_i),
      .sclk_o(eng_sclk),
      .sdo_o(eng_sdo),
      .rx_data_o(eng_rx),
      .done_o(eng_done)
   );

   // ********************************************************************
   // next state
   // ********************************************************************
   always_comb begin
      n = s;
      ev_set = `SEC_RST_8;
      ev_clr = `SEC_RST_8;
      n.ack = req && !s.ack;
      n.ld = 1'b0;
      n.tx_req = 1'b0;
      n.rx_vld = 1'b0;
      case (wb_req_i.adr)
         `SEC_ADR_EVENT: n.rdat = {24'h000000, s.ev};
         `SEC_ADR_MASK: n.rdat = {24'h000000, s.mask};
         `SEC_ADR_MODE: n.rdat = {16'h0000, s.mode};
         `SEC_ADR_DESC: n.rdat = {29'h00000000, s.tx_last, s.rx_empty, s.tx_ready};
         `SEC_ADR_TX_LEN: n.rdat = {16'h0000, s.tx_len};
         `SEC_ADR_MAX_RX: n.rdat = {16'h0000, s.max_rx};
         `SEC_ADR_RX_BASE: n.rdat = {16'h0000, s.rx_base};
         `SEC_ADR_TX_BASE: n.rdat = {16'h0000, s.tx_base};
         `SEC_ADR_RX_PTR: n.rdat = {16'h0000, s.rx_ptr};
         `SEC_ADR_TX_PTR: n.rdat = {16'h0000, s.tx_ptr};
         `SEC_ADR_STATUS: n.rdat = {14'h0000, s.mm_err, s.rx_last, s.rx_cnt};
         default: n.rdat = 32'h00000000;
      endcase
      if (ev_wr) begin
         ev_clr = wb_req_i.dat[7:0]; // [R20]
      end
      if (wr) begin
         case (wb_req_i.adr)
            `SEC_ADR_MASK: if (wb_req_i.sel[0]) n.mask = wb_req_i.dat[7:0]; // [R5]
            `SEC_ADR_MODE: n.mode = lane16(s.mode, wb_req_i.dat, wb_req_i.sel); // [R7] [R8]
            `SEC_ADR_TX_LEN: n.tx_len = lane16(s.tx_len, wb_req_i.dat, wb_req_i.sel);
            `SEC_ADR_MAX_RX: n.max_rx = lane16(s.max_rx, wb_req_i.dat, wb_req_i.sel);
            `SEC_ADR_RX_BASE: n.rx_base = lane16(s.rx_base, wb_req_i.dat, wb_req_i.sel);
            `SEC_ADR_TX_BASE: n.tx_base = lane16(s.tx_base, wb_req_i.dat, wb_req_i.sel);
            `SEC_ADR_DESC: begin
               if (wb_req_i.sel[0]) begin
                  n.tx_last = wb_req_i.dat[`SEC_DESC_TX_LAST];
                  if (wb_req_i.dat[`SEC_DESC_TX_READY]) begin
                     n.tx_ready = 1'b1;
                     n.tx_cnt = `SEC_RST_16;
                  end
                  if (wb_req_i.dat[`SEC_DESC_RX_EMPTY]) begin
                     n.rx_empty = 1'b1;
                     n.rx_cnt = `SEC_RST_16;
                     n.rx_last = 1'b0;
                     n.mm_err = 1'b0;
                  end
               end
            end
            default: ;
         endcase
      end
      if (init_wr) begin
         n.rx_ptr = s.rx_base; // [R6]
         n.tx_ptr = s.tx_base;
      end
      unique case (s.st)
         ST_IDLE: begin
            n.sel_seen = 1'b0;
            if (start_wr && enabled) begin
               n.st = ST_LOAD; // [R9]
            end
         end
         ST_LOAD: begin
            n.st = ST_SHIFT;
            if (is_master) begin
               if (s.tx_ready && s.tx_cnt < s.tx_len) begin
                  n.ld = 1'b1;
                  n.ld_data = tx_byte_i;
                  n.tx_req = 1'b1;
                  n.tx_cnt = s.tx_cnt + `SEC_ONE_16;
                  if (n.tx_cnt == s.tx_len) begin
                     // closes as the last byte is taken, before it leaves the pin
                     n.tx_ready = 1'b0; // [R2] [R10]
                     ev_set[`SEC_EV_TXB] = 1'b1;
                  end
               end else begin
                  n.st = ST_IDLE;
               end
            end else begin
               n.ld = 1'b1;
               if (s.tx_ready && s.tx_cnt < s.tx_len) begin
                  n.ld_data = tx_byte_i;
                  n.tx_req = 1'b1;
                  n.tx_cnt = s.tx_cnt + `SEC_ONE_16;
               end else begin
                  // underrun only when nothing was ever offered
                  n.ld_data = `SEC_FILL_BYTE;
                  ev_set[`SEC_EV_TXE] = !s.tx_ready && s.tx_cnt == `SEC_RST_16;
               end
            end
         end
         ST_SHIFT: begin
            if (eng_done) begin
               n.st = ST_LOAD;
               if (s.rx_empty) begin
                  n.rx_data = eng_rx;
                  n.rx_vld = 1'b1;
                  n.rx_cnt = s.rx_cnt + `SEC_ONE_16;
                  if (n.rx_cnt == s.max_rx || (is_master && s.tx_last && !s.tx_ready
                                               && s.tx_cnt == n.rx_cnt)) begin
                     n.rx_empty = 1'b0; // [R4] [R10] [R13]
                     ev_set[`SEC_EV_RXB] = 1'b1;
                  end
               end else begin
                  ev_set[`SEC_EV_BSY] = 1'b1; // [R1] [R14]
               end
               if (!is_master && s.tx_ready && s.tx_cnt == s.tx_len) begin
                  n.tx_ready = 1'b0; // [R12]
                  ev_set[`SEC_EV_TXB] = 1'b1;
               end
            end
         end
         default: n.st = ST_IDLE;
      endcase
      if (s.st != ST_IDLE && !is_master) begin
         if (!slave_select_n_i) begin
            n.sel_seen = 1'b1;
         end else if (s.sel_seen && !eng_done) begin
            n.st = ST_IDLE;
            if (s.rx_empty && s.rx_cnt != `SEC_RST_16) begin
               n.rx_empty = 1'b0; // [R11]
               n.rx_last = 1'b1;
               ev_set[`SEC_EV_RXB] = 1'b1;
            end
         end
      end
      if (s.st != ST_IDLE && is_master && enabled && !slave_select_n_i) begin
         n.st = ST_IDLE; // [R22]
         n.mm_err = 1'b1;
         n.tx_ready = 1'b0;
         n.rx_empty = 1'b0;
         ev_set[`SEC_EV_MME] = 1'b1;
      end
      // a set in the same cycle as its clear wins
      n.ev = ((s.ev & ~ev_clr) | ev_set) & `SEC_EV_USED; // [R20]
      n.irq = |(s.ev & s.mask); // [R21] [R23]
      n.sclk_oe = enabled && is_master;
      n.mosi_oe = enabled && is_master;
      n.miso_oe = enabled && !is_master && !slave_select_n_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // ********************************************************************
   // outputs
   // ********************************************************************
   assign wb_dat_o = s.rdat;
   assign wb_ack_o = s.ack;
   assign spi_sclk_o = eng_sclk;
   assign spi_sclk_oe_o = s.sclk_oe;
   assign spi_mosi_o = eng_sdo;
   assign spi_mosi_oe_o = s.mosi_oe;
   assign spi_miso_o = eng_sdo;
   assign spi_miso_oe_o = s.miso_oe;
   assign tx_byte_req_o = s.tx_req;
   assign tx_index_o = s.tx_cnt;
   assign rx_byte_o = s.rx_data;
   assign rx_byte_vld_o = s.rx_vld;
   assign rx_index_o = s.rx_cnt;
   assign irq_o = s.irq;

   // ********************************************************************
   // assertions
   // ********************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_nobuf;
      s.st == ST_SHIFT && eng_done && !s.rx_empty |=> s.ev[`SEC_EV_BSY] && !s.rx_vld;
   endproperty
   a_nobuf: assert property (p_nobuf) else $error("no-buffer event missing"); // [R1]

   property p_txb;
      s.st == ST_LOAD && is_master && s.tx_ready && s.tx_cnt + `SEC_ONE_16 == s.tx_len
      |=> s.ev[`SEC_EV_TXB] && !s.tx_ready && s.ld;
   endproperty
   a_txb: assert property (p_txb) else $error("tx buffer event late"); // [R2]

   property p_rxb;
      $rose(s.ev[`SEC_EV_RXB]) |-> !s.rx_empty && $past(s.rx_empty);
   endproperty
   a_rxb: assert property (p_rxb) else $error("rx event before close"); // [R4]

   property p_mask_rst;
      $past(rst_i) |-> s.mask == `SEC_RST_8 && s.ev == `SEC_RST_8;
   endproperty
   a_mask_rst: assert property (@(posedge clk_i) p_mask_rst) else $error("mask not reset"); // [R5]

   property p_init;
      init_wr |=> s.rx_ptr == $past(s.rx_base) && s.tx_ptr == $past(s.tx_base);
   endproperty
   a_init: assert property (p_init) else $error("ring pointers not copied"); // [R6]

   property p_full;
      s.st == ST_SHIFT && eng_done && s.rx_empty && s.rx_cnt + `SEC_ONE_16 == s.max_rx
      |=> !s.rx_empty && s.ev[`SEC_EV_RXB] && !s.ev[`SEC_EV_BSY] ##1 !s.rx_vld;
   endproperty
   a_full: assert property (p_full) else $error("full buffer not closed"); // [R14]

   property p_keep;
      !ev_wr |=> (s.ev & $past(s.ev)) == $past(s.ev);
   endproperty
   a_keep: assert property (p_keep) else $error("event flag lost"); // [R20]

   property p_irq;
      (|(s.ev & s.mask)) |=> irq_o [*2] or !(|(s.ev & s.mask));
   endproperty
   a_irq: assert property (p_irq) else $error("irq dropped early"); // [R21]

   property p_irq_off;
      !(|(s.ev & s.mask)) |=> !irq_o;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq without source"); // [R23]

   property p_mme;
      s.st != ST_IDLE && is_master && enabled && !slave_select_n_i
      |=> s.ev[`SEC_EV_MME] && s.st == ST_IDLE && s.mm_err;
   endproperty
   a_mme: assert property (p_mme) else $error("multi-master not flagged"); // [R22]

   c_rx_close: cover property ($rose(s.ev[`SEC_EV_RXB]));
   c_tx_close: cover property ($rose(s.ev[`SEC_EV_TXB]));
   c_nobuf: cover property ($rose(s.ev[`SEC_EV_BSY]));
   c_mme: cover property ($rose(s.ev[`SEC_EV_MME]));
endmodule

`default_nettype wire
